/* design/mcg_top.sv */
// master clock generator: source select, prescale, gating, apb registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module mcg_top import mcg_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic slow_rc_tick_i,
  input wire logic slow_xtal_tick_i,
  input wire logic main_tick_i,
  input wire logic pll1_tick_i,
  input wire logic pll2_tick_i,
  input wire logic cpu_sleep_i,
  output logic master_clk_en_o,
  output logic cpu_clk_en_o,
  output logic freerun_cpu_clk_en_o,
  output logic usb_port_clk_en_o,
  output logic [PERIPH_NUM-1:0] periph_clk_en_o,
  output logic [PCK_NUM-1:0] programmable_clock_out_o,
  output logic slow_rc_on_o,
  output logic slow_xtal_on_o,
  output logic [7:0] rc_trim8_o,
  output logic [7:0] rc_trim12_o,
  output logic [1:0] rc_freq_sel_o,
  output logic main_xtal_sel_o,
  output logic irq_o
);
  // registers
  logic [1:0] msrc_ff;
  logic [2:0] mdiv_ff;
  logic pll1_halve_ff;
  logic pll2_halve_ff;
  logic wlock_ff;
  logic usb_en_ff;
  logic [PCK_NUM-1:0] pck_en_ff;
  logic [2*PCK_NUM-1:0] pck_sel_ff;
  logic [PERIPH_NUM-1:0] periph_en_ff;
  logic slow_xtal_ff;
  logic slow_rc_ff;
  logic [7:0] trim8_ff;
  logic [7:0] trim12_ff;
  logic [1:0] rc_sel_ff;
  logic main_xtal_ff;
  logic [1:0] sts_ff;
  logic [1:0] mask_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic err_ff;
  // clock path state
  logic pll1_ph_ff;
  logic pll2_ph_ff;
  logic mclk_ff;
  logic cpu_ff;
  logic free_ff;
  logic usb_ff;
  logic [PERIPH_NUM-1:0] periph_ff;
  logic [PCK_NUM-1:0] pck_ff;
  logic irq_ff;
  // monitors
  logic [11:0] fail_cnt_ff;
  logic [11:0] meas_tmr_ff;
  logic [15:0] meas_cnt_ff;
  mcg_meas_t meas_st_ff;

  // decoded wires
  logic setup;
  logic wr;
  logic mapped;
  logic sel_mcfg;
  logic slow_tick;
  logic pll1_tick;
  logic pll2_tick;
  logic src_tick;
  logic fail_evt;
  logic meas_evt;
  logic meas_start;
  logic [1:0] evt;
  logic [31:0] rd_mux;
  logic [31:0] mcfg_rd;
  logic [11:0] nxt_fail_cnt;
  logic [1:0] nxt_sts;
  logic [1:0] nxt_mask;

  mcg_div_if div_if();

  // picks one of the four source ticks by a 2-bit code
  function automatic logic src_pick(input logic [1:0] code, input logic s,
                                    input logic m, input logic p1, input logic p2);
    case (code)
      SRC_SLOW: src_pick = s;
      SRC_MAIN: src_pick = m;
      SRC_PLL1: src_pick = p1;
      default: src_pick = p2;
    endcase
  endfunction

  // address match for one register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // apb decode
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && ready_ff;
  assign sel_mcfg = hit(paddr_i, ADDR_MCFG);
  assign mapped = hit(paddr_i, ADDR_CLK_EN) || hit(paddr_i, ADDR_PERIPH_EN) ||
                  hit(paddr_i, ADDR_MAIN_CTRL) || hit(paddr_i, ADDR_FREQ) || sel_mcfg ||
                  hit(paddr_i, ADDR_PCK_SEL) || hit(paddr_i, ADDR_SLOW_SEL) ||
                  hit(paddr_i, ADDR_STATUS) || hit(paddr_i, ADDR_MASK) ||
                  hit(paddr_i, ADDR_WPMR);

  // config read image, unused positions stay zero
  assign mcfg_rd = (32'(msrc_ff) << MSRC_LSB) | (32'(mdiv_ff) << MDIV_LSB) |
                   (32'(pll1_halve_ff) << PLL1_HALVE_BIT) |
                   (32'(pll2_halve_ff) << PLL2_HALVE_BIT);

  // read data selection
  assign rd_mux =
    hit(paddr_i, ADDR_MCFG) ? mcfg_rd :
    hit(paddr_i, ADDR_CLK_EN) ? ((32'(pck_en_ff) << PCK_EN_LSB) | 32'(usb_en_ff)) :
    hit(paddr_i, ADDR_PERIPH_EN) ? 32'(periph_en_ff) :
    hit(paddr_i, ADDR_MAIN_CTRL) ? ((32'(main_xtal_ff) << MAIN_XTAL_BIT) |
                                    (32'(rc_sel_ff) << RC_SEL_LSB) |
                                    (32'(trim12_ff) << TRIM12_LSB) | 32'(trim8_ff)) :
    hit(paddr_i, ADDR_FREQ) ? ((32'(meas_st_ff == MEAS_RUN) << FREQ_BUSY_BIT) |
                               32'(meas_cnt_ff)) :
    hit(paddr_i, ADDR_PCK_SEL) ? 32'(pck_sel_ff) :
    hit(paddr_i, ADDR_SLOW_SEL) ? 32'(slow_xtal_ff) :
    hit(paddr_i, ADDR_STATUS) ? 32'(sts_ff) :
    hit(paddr_i, ADDR_MASK) ? 32'(mask_ff) :
    hit(paddr_i, ADDR_WPMR) ? 32'(wlock_ff) : 32'h0;

  // bus answer: data and ready prepared in the setup cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_ff <= 32'h0;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= setup ? rd_mux : rdata_ff;
      ready_ff <= setup;
      err_ff <= setup && !mapped;
    end
  end

  // master clock config, locked by the protection bit
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      msrc_ff <= MSRC_RESET;
      mdiv_ff <= MDIV_RESET;
      pll1_halve_ff <= 1'b0;
      pll2_halve_ff <= 1'b0;
    end else if (wr && sel_mcfg && !wlock_ff) begin
      msrc_ff <= pwdata_i[MSRC_LSB +: 2];
      mdiv_ff <= pwdata_i[MDIV_LSB +: 3];
      pll1_halve_ff <= pwdata_i[PLL1_HALVE_BIT];
      pll2_halve_ff <= pwdata_i[PLL2_HALVE_BIT];
    end
  end

  // remaining software registers
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wlock_ff <= 1'b0;
      usb_en_ff <= 1'b0;
      pck_en_ff <= '0;
      pck_sel_ff <= '0;
      periph_en_ff <= '0;
      slow_xtal_ff <= 1'b0;
      slow_rc_ff <= 1'b1;
      trim8_ff <= 8'h0;
      trim12_ff <= 8'h0;
      rc_sel_ff <= RC_SEL_4MHZ;
      main_xtal_ff <= 1'b0;
      mask_ff <= 2'h0;
    end else if (wr) begin
      if (hit(paddr_i, ADDR_WPMR)) wlock_ff <= pwdata_i[0];
      if (hit(paddr_i, ADDR_CLK_EN)) begin
        usb_en_ff <= pwdata_i[USB_EN_BIT];
        pck_en_ff <= pwdata_i[PCK_EN_LSB +: PCK_NUM];
      end
      if (hit(paddr_i, ADDR_PCK_SEL)) pck_sel_ff <= pwdata_i[2*PCK_NUM-1:0];
      if (hit(paddr_i, ADDR_PERIPH_EN)) periph_en_ff <= pwdata_i[PERIPH_NUM-1:0];
      if (hit(paddr_i, ADDR_SLOW_SEL)) begin
        slow_xtal_ff <= pwdata_i[0];
        slow_rc_ff <= !pwdata_i[0];
      end
      if (hit(paddr_i, ADDR_MAIN_CTRL)) begin
        trim8_ff <= pwdata_i[7:0];
        trim12_ff <= pwdata_i[TRIM12_LSB +: 8];
        rc_sel_ff <= pwdata_i[RC_SEL_LSB +: 2];
        main_xtal_ff <= pwdata_i[MAIN_XTAL_BIT];
      end
      if (hit(paddr_i, ADDR_MASK)) mask_ff <= pwdata_i[1:0];
    end
  end

  // slow clock from the chosen oscillator only
  assign slow_tick = slow_xtal_ff ? slow_xtal_tick_i : slow_rc_tick_i;
  // pll ticks, optionally every second one
  assign pll1_tick = pll1_tick_i && (!pll1_halve_ff || pll1_ph_ff);
  assign pll2_tick = pll2_tick_i && (!pll2_halve_ff || pll2_ph_ff);
  assign src_tick = src_pick(msrc_ff, slow_tick, main_tick_i, pll1_tick, pll2_tick);

  // halving phase toggles
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pll1_ph_ff <= 1'b0;
      pll2_ph_ff <= 1'b0;
    end else begin
      pll1_ph_ff <= pll1_ph_ff ^ pll1_tick_i;
      pll2_ph_ff <= pll2_ph_ff ^ pll2_tick_i;
    end
  end

  // prescaler hookup
  assign div_if.tick = src_tick;
  assign div_if.code = mdiv_ff;
  mcg_prescaler u_master_prescale_select (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .div_if(div_if)
  );

  // clock enables, the cpu, usb and peripheral ones gated
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mclk_ff <= 1'b0;
      cpu_ff <= 1'b0;
      free_ff <= 1'b0;
      usb_ff <= 1'b0;
      periph_ff <= '0;
    end else begin
      mclk_ff <= div_if.out_tick;
      cpu_ff <= div_if.out_tick && !cpu_sleep_i;
      free_ff <= div_if.out_tick;
      usb_ff <= usb_en_ff && pll2_tick_i;
      periph_ff <= {PERIPH_NUM{div_if.out_tick}} & periph_en_ff;
    end
  end

  // programmable outputs toggle on their chosen source
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pck_ff <= '0;
    end else begin
      for (int i = 0; i < PCK_NUM; i++) begin
        if (!pck_en_ff[i]) pck_ff[i] <= 1'b0;
        else if (src_pick(pck_sel_ff[2*i +: 2], slow_tick, main_tick_i, pll1_tick,
                          pll2_tick)) pck_ff[i] <= !pck_ff[i];
      end
    end
  end

  // main crystal watchdog: cycles since the last main tick
  assign nxt_fail_cnt = (main_tick_i || !main_xtal_ff) ? 12'h0 :
                        (fail_cnt_ff == FAIL_CYCLES) ? fail_cnt_ff :
                        12'(fail_cnt_ff + 12'h1);
  assign fail_evt = (nxt_fail_cnt == FAIL_CYCLES) && (fail_cnt_ff != FAIL_CYCLES);

  // frequency counter over a fixed window
  assign meas_start = wr && hit(paddr_i, ADDR_FREQ);
  assign meas_evt = (meas_st_ff == MEAS_RUN) && (meas_tmr_ff == 12'h0);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fail_cnt_ff <= 12'h0;
      meas_st_ff <= MEAS_IDLE;
      meas_tmr_ff <= 12'h0;
      meas_cnt_ff <= 16'h0;
    end else begin
      fail_cnt_ff <= nxt_fail_cnt;
      case (meas_st_ff)
        MEAS_IDLE: begin
          if (meas_start) begin
            meas_st_ff <= MEAS_RUN;
            meas_tmr_ff <= 12'(MEAS_CYCLES - 12'h1);
            meas_cnt_ff <= 16'h0;
          end
        end
        MEAS_RUN: begin
          if (main_tick_i) meas_cnt_ff <= 16'(meas_cnt_ff + 16'h1);
          if (meas_tmr_ff == 12'h0) meas_st_ff <= MEAS_IDLE;
          else meas_tmr_ff <= 12'(meas_tmr_ff - 12'h1);
        end
        default: meas_st_ff <= MEAS_IDLE;
      endcase
    end
  end

  // sticky status, a new event beats a write-one clear
  assign evt = {meas_evt, fail_evt};
  assign nxt_sts = evt | (sts_ff & ~((wr && hit(paddr_i, ADDR_STATUS)) ? pwdata_i[1:0] : 2'h0));
  // mask as it stands after this edge, so irq never lags a mask write
  assign nxt_mask = (wr && hit(paddr_i, ADDR_MASK)) ? pwdata_i[1:0] : mask_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sts_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      irq_ff <= |(nxt_sts & nxt_mask);
    end
  end

  // outputs
  assign prdata_o = rdata_ff;
  assign pready_o = ready_ff;
  assign pslverr_o = err_ff;
  assign master_clk_en_o = mclk_ff;
  assign cpu_clk_en_o = cpu_ff;
  assign freerun_cpu_clk_en_o = free_ff;
  assign usb_port_clk_en_o = usb_ff;
  assign periph_clk_en_o = periph_ff;
  assign programmable_clock_out_o = pck_ff;
  assign slow_rc_on_o = slow_rc_ff;
  assign slow_xtal_on_o = slow_xtal_ff;
  assign rc_trim8_o = trim8_ff;
  assign rc_trim12_o = trim12_ff;
  assign rc_freq_sel_o = rc_sel_ff;
  assign main_xtal_sel_o = main_xtal_ff;
  assign irq_o = irq_ff;

  chk_wp_lock: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (wr && sel_mcfg && wlock_ff) |=> $stable(mcfg_rd)) else $error("locked config changed");
  chk_wp_open: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (wr && sel_mcfg && !wlock_ff) |=> msrc_ff == $past(pwdata_i[1:0]))
    else $error("open config write lost");
  chk_reset_main: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> (msrc_ff == SRC_MAIN && rc_freq_sel_o == RC_SEL_4MHZ))
    else $error("not on 4 MHz main after reset");
  chk_sleep_gate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cpu_sleep_i |=> !cpu_clk_en_o) else $error("cpu clock ran in sleep");
  chk_free_run: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    div_if.out_tick |=> freerun_cpu_clk_en_o) else $error("free clock missed a tick");
  chk_periph_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    periph_clk_en_o != 0 |-> ($past(periph_en_ff) & periph_clk_en_o) == periph_clk_en_o)
    else $error("disabled peripheral clocked");
  chk_slow_one: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    slow_rc_on_o != slow_xtal_on_o) else $error("slow oscillators both on or off");
  chk_fail_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    fail_evt |=> sts_ff[STS_FAIL]) else $error("clock failure not flagged");
  chk_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (sts_ff & mask_ff) != 2'h0 |-> irq_o) else $error("irq low with pending event");
  chk_pll1_half: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (pll1_halve_ff && pll1_tick) |-> pll1_ph_ff) else $error("pll1 not halved");
endmodule

/* design/mcg_pkg.sv */
// register map, field layout and timing constants of the master clock generator
// What this block does
// - source code picks slow, main, pll1, pll2
// - prescale codes 0-6 power of two, 7 thirds
// - bit 12 halves first pll clock
// - config writes ignored while protection set
// - reset runs master clock from 4 MHz RC
// - cpu clock stops during processor sleep
// - free-running cpu clock ignores sleep
// - each peripheral clock enabled independently
// - slow clock from RC or crystal, other off
// - software trims 8 and 12 MHz RC
// - clock outputs pick a generator clock
// - detect main crystal clock failure
// - count main clock, retune RC on the fly
// - usb port gets its own clock
// - master clock feeds permanent modules, programmable
package mcg_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_CLK_EN = 32'h400e0400;
  localparam logic [31:0] ADDR_PERIPH_EN = 32'h400e0410;
  localparam logic [31:0] ADDR_MAIN_CTRL = 32'h400e0420;
  localparam logic [31:0] ADDR_FREQ = 32'h400e0424;
  localparam logic [31:0] ADDR_MCFG = 32'h400e0430;
  localparam logic [31:0] ADDR_PCK_SEL = 32'h400e0440;
  localparam logic [31:0] ADDR_SLOW_SEL = 32'h400e0450;
  localparam logic [31:0] ADDR_STATUS = 32'h400e0468;
  localparam logic [31:0] ADDR_MASK = 32'h400e046c;
  localparam logic [31:0] ADDR_WPMR = 32'h400e04e4;
  // master clock config fields
  localparam int MSRC_LSB = 0;
  localparam int MDIV_LSB = 4;
  localparam int PLL1_HALVE_BIT = 12;
  localparam int PLL2_HALVE_BIT = 13;
  localparam logic [1:0] MSRC_RESET = 2'h1;
  localparam logic [2:0] MDIV_RESET = 3'h0;
  localparam logic [2:0] MDIV_THIRD = 3'h7;
  localparam logic [6:0] MDIV_THIRD_LAST = 7'h2;
  // source codes
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_PLL1 = 2'h2;
  localparam logic [1:0] SRC_PLL2 = 2'h3;
  // other field positions
  localparam int USB_EN_BIT = 0;
  localparam int PCK_EN_LSB = 8;
  localparam int PCK_NUM = 3;
  localparam int PERIPH_NUM = 8;
  localparam int TRIM12_LSB = 8;
  localparam int RC_SEL_LSB = 16;
  localparam int MAIN_XTAL_BIT = 24;
  localparam int FREQ_BUSY_BIT = 16;
  localparam int STS_FAIL = 0;
  localparam int STS_MEAS = 1;
  localparam logic [1:0] RC_SEL_4MHZ = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAIL_TIME_NS = 2000;
  localparam int MEAS_TIME_NS = 4000;
  localparam logic [11:0] FAIL_CYCLES = 12'((FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] MEAS_CYCLES = 12'(MEAS_TIME_NS / CLK_PERIOD_NS);
  typedef enum logic {MEAS_IDLE, MEAS_RUN} mcg_meas_t;
endpackage

/* design/mcg_div_if.sv */
// link between the top and the master prescaler
`timescale 1ns/1ns
interface mcg_div_if;
  logic tick;
  logic [2:0] code;
  logic out_tick;
  modport ctrl(output tick, output code, input out_tick);
  modport div(input tick, input code, output out_tick);
endinterface

/* design/mcg_prescaler.sv */
// master clock prescaler working on source tick pulses
`timescale 1ns/1ns
module mcg_prescaler import mcg_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  mcg_div_if.div div_if
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic [6:0] last_cnt;
  logic wrap;
  logic out_ff;

  // terminal count: code 7 divides by 3, others by two to the code
  assign last_cnt = (div_if.code == MDIV_THIRD) ? MDIV_THIRD_LAST :
                    7'((7'h1 << div_if.code) - 7'h1);
  assign wrap = div_if.tick && (cnt_ff >= last_cnt);
  assign nxt_cnt = !div_if.tick ? cnt_ff : (wrap ? 7'h0 : 7'(cnt_ff + 7'h1));
  assign div_if.out_tick = out_ff;

  // counter and output pulse
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= 7'h0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= wrap;
    end
  end

  chk_div_cause: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    out_ff |-> $past(div_if.tick)) else $error("prescaler pulse without source tick");
  chk_div_bypass: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (div_if.tick && div_if.code == 3'h0 && cnt_ff == 7'h0) |=> out_ff)
    else $error("divide by one dropped a tick");
endmodule

/* design/mcg_prescaler_unused_guard.sv */
// spare design file, holds no logic

/* sim/mcg_osc_model.sv */
// oscillator model: tick pulses of every clock source feeding the generator
`timescale 1ns/1ns
module mcg_osc_model #(
  parameter int SLOW_P = 16,
  parameter int XTAL_P = 20,
  parameter int MAIN_P = 4,
  parameter int PLL1_P = 2,
  parameter int PLL2_P = 3
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic main_run_i,
  output logic [4:0] ticks_o
);
  localparam int PER [5] = '{SLOW_P, XTAL_P, MAIN_P, PLL1_P, PLL2_P};
  // one period counter per source, a tick at each wrap
  for (genvar i = 0; i < 5; i++) begin : g_src
    logic [7:0] cnt_ff;
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || cnt_ff == 8'(PER[i] - 1)) begin
        cnt_ff <= 8'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
    // a stopped main oscillator gives no ticks at all
    assign ticks_o[i] = rstn_i && cnt_ff == 8'h00 && (i != 2 || main_run_i);
  end
endmodule

/* sim/tb.sv */
// self-checking bench for the master clock generator
`timescale 1ns/1ns
module tb import mcg_pkg::*;;
  localparam int CP [4] = '{16, 4, 2, 3};
  localparam int N = 1536;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic main_run = 1'b1;
  logic cnt_clr = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, mclk, cpu, frc, usb, rc_on, xt_on, xsel, irq;
  logic [4:0] tk;
  logic [7:0] per, per_seen, trim8, trim12;
  logic [2:0] pck, pck_prev;
  logic [1:0] fsel;
  int n_mclk, n_cpu, n_frc, n_usb, cycles, n_mismatch, total_checks;
  int n_pck [3];

  mcg_osc_model #(.SLOW_P(CP[0]), .MAIN_P(CP[1]), .PLL1_P(CP[2]), .PLL2_P(CP[3]))
    mcg_osc_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .main_run_i(main_run),
    .ticks_o(tk));

  mcg_top mcg_top_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .slow_rc_tick_i(tk[0]),
    .slow_xtal_tick_i(tk[1]), .main_tick_i(tk[2]), .pll1_tick_i(tk[3]), .pll2_tick_i(tk[4]),
    .cpu_sleep_i(sleep), .master_clk_en_o(mclk), .cpu_clk_en_o(cpu),
    .freerun_cpu_clk_en_o(frc), .usb_port_clk_en_o(usb), .periph_clk_en_o(per),
    .programmable_clock_out_o(pck), .slow_rc_on_o(rc_on), .slow_xtal_on_o(xt_on),
    .rc_trim8_o(trim8), .rc_trim12_o(trim12), .rc_freq_sel_o(fsel),
    .main_xtal_sel_o(xsel), .irq_o(irq));

  // clock and hang guard
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      results();
    end
  end

  // pulse and toggle counters over one measuring window
  always @(posedge sys_clk_i) begin
    pck_prev <= pck;
    if (cnt_clr) begin
      n_mclk <= 0;
      n_cpu <= 0;
      n_frc <= 0;
      n_usb <= 0;
      n_pck <= '{0, 0, 0};
      per_seen <= 8'h00;
    end else begin
      n_mclk <= n_mclk + int'(mclk);
      n_cpu <= n_cpu + int'(cpu);
      n_frc <= n_frc + int'(frc);
      n_usb <= n_usb + int'(usb);
      per_seen <= per_seen | per;
      for (int i = 0; i < 3; i++) begin
        n_pck[i] <= n_pck[i] + int'(pck[i] != pck_prev[i]);
      end
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic near(input int a, input int b);
    return (a <= b + 1) && (b <= a + 1);
  endfunction

  // one apb transfer: setup, access, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic measure();
    @(posedge sys_clk_i);
    cnt_clr <= 1'b1;
    @(posedge sys_clk_i);
    cnt_clr <= 1'b0;
    repeat (N) @(posedge sys_clk_i);
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rdchk("config reset", ADDR_MCFG, 32'h00000001);
    rdchk("mask reset", ADDR_MASK, 32'h0);
    check("rc freq reset", 32'(fsel), 32'(RC_SEL_4MHZ));
    check("slow rc on", 32'({xt_on, rc_on}), 32'h1);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MCFG, 32'(c));
      measure();
      check("source ticks", 32'(near(n_mclk, N / CP[c])), 32'h1);
      check("cpu ticks", 32'(n_cpu), 32'(n_mclk));
      check("free ticks", 32'(n_frc), 32'(n_mclk));
    end
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_MCFG, 32'h1 | 32'(p << MDIV_LSB));
      measure();
      check("prescaled ticks", 32'(near(n_mclk, N / CP[1] / (p == 7 ? 3 : 1 << p))), 32'h1);
    end
    wr(ADDR_MCFG, (32'h1 << PLL1_HALVE_BIT) | 32'h2);
    measure();
    check("pll1 halved", 32'(near(n_mclk, N / CP[2] / 2)), 32'h1);
    wr(ADDR_MCFG, (32'h1 << PLL2_HALVE_BIT) | 32'h3);
    measure();
    check("pll2 halved", 32'(near(n_mclk, N / CP[3] / 2)), 32'h1);
    $display("test source and prescale done");
    wr(ADDR_MCFG, 32'h1);
    sleep <= 1'b1;
    measure();
    sleep <= 1'b0;
    check("sleep cpu ticks", 32'(n_cpu), 32'h0);
    check("sleep free ticks", 32'(near(n_frc, N / CP[1])), 32'h1);
    $display("test sleep done");
    wr(ADDR_WPMR, 32'h1);
    wr(ADDR_MCFG, 32'h00000052);
    rdchk("locked config", ADDR_MCFG, 32'h00000001);
    wr(ADDR_WPMR, 32'h0);
    wr(ADDR_MCFG, 32'hffffffff);
    rdchk("open config", ADDR_MCFG, 32'h00003073);
    wr(ADDR_MCFG, 32'h1);
    $display("test write protect done");
    wr(ADDR_CLK_EN, 32'h00000301);
    wr(ADDR_PCK_SEL, 32'h00000001);
    wr(ADDR_PERIPH_EN, 32'h0000005a);
    measure();
    check("usb ticks", 32'(near(n_usb, N / CP[3])), 32'h1);
    check("out0 toggles", 32'(near(n_pck[0], N / CP[1])), 32'h1);
    check("out1 toggles", 32'(near(n_pck[1], N / CP[0])), 32'h1);
    check("out2 toggles", 32'(n_pck[2]), 32'h0);
    check("periph seen", 32'(per_seen), 32'h5a);
    wr(ADDR_CLK_EN, 32'h0);
    wr(ADDR_PERIPH_EN, 32'h0);
    measure();
    check("usb off", 32'(n_usb), 32'h0);
    check("periph off", 32'(per_seen), 32'h0);
    check("outputs off", 32'(pck), 32'h0);
    $display("test gating done");
    wr(ADDR_SLOW_SEL, 32'h1);
    settle();
    check("slow crystal", 32'({xt_on, rc_on}), 32'h2);
    wr(ADDR_SLOW_SEL, 32'h0);
    settle();
    check("slow rc", 32'({xt_on, rc_on}), 32'h1);
    wr(ADDR_MAIN_CTRL, 32'h01023ca5);
    settle();
    check("trim fields", 32'({xsel, fsel, trim12, trim8}), 32'h00063ca5);
    $display("test slow and trim done");
    wr(ADDR_MASK, 32'h2);
    wr(ADDR_FREQ, 32'h0);
    do begin
      apb(1'b0, ADDR_FREQ, 32'h0);
    end while (rd[FREQ_BUSY_BIT] !== 1'b0);
    check("main count", 32'(near(int'(rd[15:0]), int'(MEAS_CYCLES) / CP[1])), 32'h1);
    rdchk("measure status", ADDR_STATUS, 32'h2);
    check("irq raised", 32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h2);
    settle();
    check("irq cleared", 32'(irq), 32'h0);
    main_run <= 1'b0;
    repeat (int'(FAIL_CYCLES) + 50) @(posedge sys_clk_i);
    main_run <= 1'b1;
    rdchk("fail status", ADDR_STATUS, 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    wr(ADDR_MASK, 32'h1);
    settle();
    check("irq unmasked", 32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    settle();
    check("irq fail cleared", 32'(irq), 32'h0);
    $display("test measure and failure done");
    apb(1'b0, 32'h400e0404, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test unmapped done");
    results();
  end
endmodule
